// file: dtc_pkg.sv
// shared constants and types for the dynamic termination control link
package dtc_pkg;
   // mode field layout
   localparam int WR_TERM_W   = 2;
   localparam int NOM_TERM_W  = 3;
   localparam int LAT_W       = 5;
   localparam int CNT_W       = 5;
   // write termination codes
   localparam logic [1:0] WR_TERM_OFF  = 2'h0;
   localparam logic [1:0] WR_TERM_Q4   = 2'h1;
   localparam logic [1:0] WR_TERM_Q2   = 2'h2;
   // nominal termination codes
   localparam logic [2:0] NOM_OFF      = 3'h0;
   localparam logic [2:0] NOM_Q4       = 3'h1;
   localparam logic [2:0] NOM_Q2       = 3'h2;
   localparam logic [2:0] NOM_Q6       = 3'h3;
   localparam logic [2:0] NOM_Q12      = 3'h4;
   localparam logic [2:0] NOM_Q8       = 3'h5;
   // strength divisors of RZQ, 0 meaning no termination
   localparam logic [3:0] DIV_NONE     = 4'h0;
   localparam logic [3:0] DIV_2        = 4'h2;
   localparam logic [3:0] DIV_4        = 4'h4;
   localparam logic [3:0] DIV_6        = 4'h6;
   localparam logic [3:0] DIV_8        = 4'h8;
   localparam logic [3:0] DIV_12       = 4'hc;
   // timing counts in link clocks
   localparam logic [CNT_W-1:0] SW_IN_OFS        = 5'h2;
   localparam logic [CNT_W-1:0] RET_SHORT_BASE   = 5'h4;
   localparam logic [CNT_W-1:0] RET_LONG_BASE    = 5'h6;
   localparam logic [CNT_W-1:0] MIN_HIGH_SHORT   = 5'h4;
   localparam logic [CNT_W-1:0] MIN_HIGH_LONG    = 5'h6;
   localparam logic [CNT_W-1:0] MODE_SET_DELAY   = 5'hc;
   localparam logic [CNT_W-1:0] SKEW_EXTRA       = 5'h1;
   localparam logic [3:0]       LINK_DIV_HALF    = 4'h1;
   // reset values of the mode fields
   localparam logic [1:0] WR_TERM_RST  = 2'h0;
   localparam logic [2:0] NOM_TERM_RST = 3'h0;
   // host command codes
   typedef enum logic [1:0] {
      DTC_CMD_NOP   = 2'b00,
      DTC_CMD_WRITE = 2'b01,
      DTC_CMD_MODE  = 2'b10
   } dtc_cmd_t;
endpackage

// file: dtc_link_if.sv
// link between the memory controller end and the termination device end
`timescale 1ns/10ps
interface dtc_link_if;
   import dtc_pkg::*;
   logic                  link_clk;
   logic                  term_pin;
   dtc_cmd_t              cmd;
   logic                  burst_chop;
   logic [WR_TERM_W-1:0]  mode_wr_term;
   logic [NOM_TERM_W-1:0] mode_nom_term;
   logic                  mode_wr_level;
   logic [LAT_W-1:0]      mode_cwl;
   logic [LAT_W-1:0]      mode_al;
   modport ctrl (output link_clk, term_pin, cmd, burst_chop, mode_wr_term,
                 mode_nom_term, mode_wr_level, mode_cwl, mode_al);
   modport dev  (input link_clk, term_pin, cmd, burst_chop, mode_wr_term,
                 mode_nom_term, mode_wr_level, mode_cwl, mode_al);
endinterface

// file: dtc_device.sv
// termination device end: nominal and dynamic write termination control
`timescale 1ns/10ps
// Operation
// - either write-termination bit set enables switching
// - controller keeps write termination off, dll disabled
// - write field: off, RZQ/4, RZQ/2, reserved
// - nominal field decodes six strengths, two reserved
// - nominal during writes only RZQ/2/4/6
// - idle uses nominal, pin with on/off latency
// - write strength at write latency minus two
// - return after 4 or 6 plus off latency
// - on/off still follows pin during writes
// - controller holds pin high 4 or 6 clocks
// - value undefined in change skew window
// - single rank may tie pin high
// - leveling loads: write term off, nominal paired; controller forces write term off for leveling only when tied high
// - termination uncertain for bounded time after load
// - on/off latency equals cwl plus al minus two
// - controller drives pin low around reads unless tied high
module dtc_device
   import dtc_pkg::*;
(
   dtc_link_if.dev        link,
   input  wire logic      rst_n,
   output logic [3:0]     dq_term_div,
   output logic [3:0]     dqs_term_div,
   output logic           term_on,
   output logic           wr_strength,
   output logic           term_unsettled
);
   ////////////////////////////////////////////////////////////////////////////
   // decode functions
   function automatic logic [3:0] nom_div(input logic [2:0] code);
      logic [3:0] d;
      d = DIV_NONE;
      if (code == NOM_Q4) begin
         d = DIV_4;
      end else if (code == NOM_Q2) begin
         d = DIV_2;
      end else if (code == NOM_Q6) begin
         d = DIV_6;
      end else if (code == NOM_Q12) begin
         d = DIV_12;
      end else if (code == NOM_Q8) begin
         d = DIV_8;
      end
      return d;
   endfunction

   function automatic logic [3:0] wr_div(input logic [1:0] code);
      logic [3:0] d;
      d = DIV_NONE;
      if (code == WR_TERM_Q4) begin
         d = DIV_4;
      end else if (code == WR_TERM_Q2) begin
         d = DIV_2;
      end
      return d;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // mode state, all on the link clock since the device runs from it
   logic [WR_TERM_W-1:0]  wr_term;
   logic [NOM_TERM_W-1:0] nom_term;
   logic                  wr_level;
   logic [LAT_W-1:0]      cwl;
   logic [LAT_W-1:0]      al;
   logic [CNT_W-1:0]      settle_cnt;
   logic                  pin_q;
   logic [31:0]           pin_hist;
   logic [CNT_W-1:0]      sw_in_cnt;
   logic [CNT_W-1:0]      ret_cnt;
   logic                  wr_active;

   wire logic             is_write   = (link.cmd == DTC_CMD_WRITE);
   wire logic             is_mode    = (link.cmd == DTC_CMD_MODE);
   wire logic             dyn_en     = wr_term[0] | wr_term[1];
   wire logic [CNT_W-1:0] pin_lat    = CNT_W'(cwl + al - SW_IN_OFS);
   wire logic             pin_late   = pin_hist[pin_lat];
   wire logic [CNT_W-1:0] ret_len    = CNT_W'((link.burst_chop ? RET_SHORT_BASE :
                                       RET_LONG_BASE) + pin_lat);
   wire logic [3:0]       base_div   = nom_div(nom_term);
   wire logic [3:0]       act_div    = wr_active ? wr_div(wr_term) : base_div;
   wire logic             next_on    = pin_late;
   wire logic [3:0]       next_dq    = (!next_on || wr_level) ? DIV_NONE : act_div;
   wire logic [3:0]       next_dqs   = next_on ? act_div : DIV_NONE;

   always_ff @(posedge link.link_clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_term    <= WR_TERM_RST;
         nom_term   <= NOM_TERM_RST;
         wr_level   <= 1'b0;
         cwl        <= '0;
         al         <= '0;
         settle_cnt <= '0;
      end else if (is_mode) begin
         wr_term    <= link.mode_wr_term;
         nom_term   <= link.mode_nom_term;
         wr_level   <= link.mode_wr_level;
         cwl        <= link.mode_cwl;
         al         <= link.mode_al;
         // uncertainty spans latency, skew, mode delay and one clock
         settle_cnt <= CNT_W'(pin_lat + SKEW_EXTRA + MODE_SET_DELAY + SKEW_EXTRA);
      end else if (settle_cnt != '0) begin
         settle_cnt <= settle_cnt - 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // pin sampling and write tracking, rising edges only
   always_ff @(posedge link.link_clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_q    <= 1'b0;
         pin_hist <= '0;
      end else begin
         pin_q    <= link.term_pin;
         pin_hist <= {pin_hist[30:0], pin_q};
      end
   end

   always_ff @(posedge link.link_clk or negedge rst_n) begin
      if (!rst_n) begin
         sw_in_cnt <= '0;
         ret_cnt   <= '0;
         wr_active <= 1'b0;
      end else if (is_write && dyn_en) begin
         // a fresh write restarts both counts
         sw_in_cnt <= CNT_W'(cwl + al - SW_IN_OFS);
         ret_cnt   <= ret_len;
         wr_active <= wr_active || (cwl + al == SW_IN_OFS);
      end else begin
         if (sw_in_cnt != '0) begin
            sw_in_cnt <= sw_in_cnt - 1'b1;
         end
         if (ret_cnt != '0) begin
            ret_cnt <= ret_cnt - 1'b1;
         end
         if (sw_in_cnt == 5'h1) begin
            wr_active <= 1'b1;
         end else if (ret_cnt == 5'h1) begin
            wr_active <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // registered outputs
   always_ff @(posedge link.link_clk or negedge rst_n) begin
      if (!rst_n) begin
         dq_term_div    <= DIV_NONE;
         dqs_term_div   <= DIV_NONE;
         term_on        <= 1'b0;
         wr_strength    <= 1'b0;
         term_unsettled <= 1'b0;
      end else begin
         dq_term_div    <= next_dq;
         dqs_term_div   <= next_dqs;
         term_on        <= next_on;
         wr_strength    <= wr_active;
         // switch-in edge marks the change-skew window
         term_unsettled <= (settle_cnt != '0) || (sw_in_cnt == 5'h1);
      end
   end
endmodule

// file: dtc_ctrl.sv
// memory controller end: drives link clock, termination pin, commands and mode loads
`timescale 1ns/10ps
module dtc_ctrl
   import dtc_pkg::*;
(
   input  wire logic                  sys_clk,
   input  wire logic                  rst_n,
   input  wire logic                  req_valid,
   input  wire logic [1:0]            req_cmd,
   input  wire logic                  req_chop,
   input  wire logic                  req_term,
   input  wire logic                  req_read,
   input  wire logic [WR_TERM_W-1:0]  req_wr_term,
   input  wire logic [NOM_TERM_W-1:0] req_nom_term,
   input  wire logic                  req_wr_level,
   input  wire logic                  req_dll_off,
   input  wire logic                  tied_high,
   input  wire logic [LAT_W-1:0]      req_cwl,
   input  wire logic [LAT_W-1:0]      req_al,
   output logic                       req_ready,
   dtc_link_if.ctrl                   link
);
   ////////////////////////////////////////////////////////////////////////////
   // link clock is sys_clk divided by two; commands change on its falling edge
   logic            clk_div;
   logic            pin_r;
   dtc_cmd_t        cmd_r;
   logic            chop_r;
   logic [1:0]      wr_term_r;
   logic [2:0]      nom_r;
   logic            wl_r;
   logic [4:0]      cwl_r;
   logic [4:0]      al_r;
   logic [CNT_W-1:0] hold_cnt;

   wire logic launch  = clk_div && req_valid && req_ready;
   wire logic is_wr   = launch && (req_cmd == DTC_CMD_WRITE);
   wire logic is_md   = launch && (req_cmd == DTC_CMD_MODE);
   // write termination forced off with dll off or during leveling when tied high
   wire logic [1:0] safe_wr = (req_dll_off || (tied_high && req_wr_level)) ?
                              WR_TERM_OFF : req_wr_term;
   // nominal limited to write-safe strengths, and off when tied high outside leveling
   wire logic [2:0] safe_nom = (tied_high && !req_wr_level) ? NOM_OFF :
                               ((req_nom_term == NOM_Q12) || (req_nom_term > NOM_Q8)) ?
                               NOM_Q2 : (req_nom_term == NOM_Q8 ? NOM_Q2 : req_nom_term);
   wire logic want_pin = (tied_high || req_term) && !(req_read && !tied_high);
   wire logic hold_now = (hold_cnt != '0);
   wire logic next_pin = launch ? (want_pin || (hold_now && pin_r)) :
                         (hold_now ? pin_r : pin_r);

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         clk_div   <= 1'b0;
         req_ready <= 1'b0;
      end else begin
         clk_div   <= ~clk_div;
         req_ready <= 1'b1;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_r     <= 1'b0;
         cmd_r     <= DTC_CMD_NOP;
         chop_r    <= 1'b0;
         wr_term_r <= WR_TERM_RST;
         nom_r     <= NOM_TERM_RST;
         wl_r      <= 1'b0;
         cwl_r     <= '0;
         al_r      <= '0;
         hold_cnt  <= '0;
      end else if (clk_div) begin
         cmd_r  <= launch ? dtc_cmd_t'(req_cmd) : DTC_CMD_NOP;
         chop_r <= req_chop;
         if (is_md) begin
            wr_term_r <= safe_wr;
            nom_r     <= safe_nom;
            wl_r      <= req_wr_level;
            cwl_r     <= req_cwl;
            al_r      <= req_al;
         end
         // pin may only fall once the minimum-high count expires
         if (hold_now) begin
            hold_cnt <= hold_cnt - 1'b1;
         end
         // a write launched together with the pin rising is registered with the pin high
         if (is_wr && (pin_r || want_pin)) begin
            hold_cnt <= req_chop ? MIN_HIGH_SHORT : MIN_HIGH_LONG;
         end else if (!pin_r && want_pin && launch) begin
            hold_cnt <= MIN_HIGH_SHORT;
         end
         pin_r <= (launch && !want_pin && hold_now) ? 1'b1 : next_pin;
      end
   end

   assign link.link_clk      = clk_div;
   assign link.term_pin      = pin_r;
   assign link.cmd           = cmd_r;
   assign link.burst_chop    = chop_r;
   assign link.mode_wr_term  = wr_term_r;
   assign link.mode_nom_term = nom_r;
   assign link.mode_wr_level = wl_r;
   assign link.mode_cwl      = cwl_r;
   assign link.mode_al       = al_r;
endmodule

// file: dtc_assertions.sv
// concurrent checks on the termination link and the device outputs
`timescale 1ns/10ps
module dtc_assertions
   import dtc_pkg::*;
(
   input  wire logic                  link_clk,
   input  wire logic                  rst_n,
   input  wire logic                  term_pin,
   input  wire dtc_cmd_t              cmd,
   input  wire logic                  burst_chop,
   input  wire logic [WR_TERM_W-1:0]  mode_wr_term,
   input  wire logic [NOM_TERM_W-1:0] mode_nom_term,
   input  wire logic                  mode_wr_level,
   input  wire logic [3:0]            dq_term_div,
   input  wire logic [3:0]            dqs_term_div,
   input  wire logic                  term_on,
   input  wire logic                  wr_strength,
   input  wire logic                  term_unsettled
);
   default clocking cb @(posedge link_clk);
   endclocking
   default disable iff (!rst_n);
   sequence s_write_hi;
      cmd == DTC_CMD_WRITE && term_pin;
   endsequence
   sequence s_settled_wr;
      wr_strength && term_on && !term_unsettled && !mode_wr_level;
   endsequence
   ////////////////////////////////////////////////////////////////////////////////
   a_pin_min_high: assert property ($rose(term_pin) |-> term_pin[*4])
      else $error("termination pin released before short minimum");
   a_pin_hold_short: assert property (s_write_hi ##0 burst_chop |-> term_pin[*4])
      else $error("pin dropped within short hold after chopped write");
   a_pin_hold_long: assert property (s_write_hi ##0 !burst_chop |-> term_pin[*6])
      else $error("pin dropped within long hold after full write");
   a_nom_legal: assert property (cmd == DTC_CMD_MODE |-> mode_nom_term <= NOM_Q6)
      else $error("nominal code outside write-safe set");
   a_level_wr_off: assert property (cmd == DTC_CMD_MODE && mode_wr_level
      |-> mode_wr_term == WR_TERM_OFF)
      else $error("write termination left on for leveling");
   a_switch_in: assert property (cmd == DTC_CMD_WRITE && mode_wr_term != WR_TERM_OFF
      |-> ##[0:40] wr_strength)
      else $error("write strength never applied after write");
   a_no_switch: assert property (mode_wr_term == WR_TERM_OFF && $stable(mode_wr_term)
      |=> !$rose(wr_strength))
      else $error("write strength with switching disabled");
   a_wr_div: assert property (s_settled_wr |-> dq_term_div ==
      ((mode_wr_term == WR_TERM_Q4) ? DIV_4 : DIV_2))
      else $error("wrong write termination divisor");
   a_off_none: assert property (!term_on && !term_unsettled
      |-> dq_term_div == DIV_NONE && dqs_term_div == DIV_NONE)
      else $error("termination applied while off");
endmodule

// file: tb_dynamic_termination_ctrl.sv
// self-checking bench: controller end and device end joined by the link
`timescale 1ns/10ps
module tb_dynamic_termination_ctrl;
   import dtc_pkg::*;
   logic                  sys_clk, rst_n, req_valid, req_chop, req_term, req_read;
   logic [1:0]            req_cmd;
   logic [WR_TERM_W-1:0]  req_wr_term;
   logic [NOM_TERM_W-1:0] req_nom_term;
   logic                  req_wr_level, req_dll_off, tied_high, req_ready;
   logic [LAT_W-1:0]      req_cwl, req_al;
   logic [3:0]            dq_term_div, dqs_term_div, dv;
   logic                  term_on, wr_strength, term_unsettled;
   int                    miscompares, samples_checked, cycles, n, seed;
   dtc_link_if lnk();
   dtc_ctrl i_dtc_ctrl (.sys_clk(sys_clk), .rst_n(rst_n), .req_valid(req_valid),
      .req_cmd(req_cmd), .req_chop(req_chop), .req_term(req_term), .req_read(req_read),
      .req_wr_term(req_wr_term), .req_nom_term(req_nom_term), .req_wr_level(req_wr_level),
      .req_dll_off(req_dll_off), .tied_high(tied_high), .req_cwl(req_cwl), .req_al(req_al),
      .req_ready(req_ready), .link(lnk.ctrl));
   dtc_device i_dtc_device (.link(lnk.dev), .rst_n(rst_n), .dq_term_div(dq_term_div),
      .dqs_term_div(dqs_term_div), .term_on(term_on), .wr_strength(wr_strength),
      .term_unsettled(term_unsettled));
   dtc_assertions i_dtc_assertions (.link_clk(lnk.link_clk), .rst_n(rst_n),
      .term_pin(lnk.term_pin), .cmd(lnk.cmd), .burst_chop(lnk.burst_chop),
      .mode_wr_term(lnk.mode_wr_term), .mode_nom_term(lnk.mode_nom_term),
      .mode_wr_level(lnk.mode_wr_level), .dq_term_div(dq_term_div),
      .dqs_term_div(dqs_term_div), .term_on(term_on), .wr_strength(wr_strength),
      .term_unsettled(term_unsettled));
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end
   // ceiling well above the roughly 3100 cycles the sequence needs
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         test_done();
      end
   end
   function automatic logic [3:0] exp_wr(input logic [1:0] c);
      return (c == 2'h1) ? DIV_4 : (c == 2'h2) ? DIV_2 : DIV_NONE;
   endfunction
   // 20 and 30 ohm and reserved codes are folded to the 120 ohm setting
   function automatic logic [3:0] exp_nom(input logic [2:0] c);
      return (c == 3'h0) ? DIV_NONE : (c == 3'h1) ? DIV_4 : (c == 3'h3) ? DIV_6 : DIV_2;
   endfunction
   task automatic chk_div(input logic [3:0] got, input logic [3:0] exp);
      samples_checked++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_cnt(input logic [7:0] got, input logic [7:0] exp);
      chk_div(got[3:0], exp[3:0]);
   endtask
   // request held until an edge that sees ready with the link clock high
   task automatic req(input logic [1:0] c);
      int k;
      req_cmd = c;
      req_valid = 1'b1;
      for (k = 0; k < 50; k++) begin
         @(negedge sys_clk);
         if (req_ready === 1'b1 && lnk.link_clk === 1'b1) break;
      end
      @(posedge sys_clk);
      #1 req_valid = 1'b0;
      req_cmd = DTC_CMD_NOP;
   endtask
   task automatic set_mode(input logic [1:0] w, input logic [2:0] m, input logic l);
      req_wr_term = w;
      req_nom_term = m;
      req_wr_level = l;
      req(DTC_CMD_MODE);
      repeat (60) @(posedge sys_clk);
      #1;
   endtask
   // one write with the pin high; counts link cycles of write strength
   task automatic wr_burst(input logic ch);
      req_chop = ch;
      req_term = 1'b1;
      req(DTC_CMD_WRITE);
      n = 0;
      dv = DIV_NONE;
      repeat (40) begin
         @(posedge lnk.link_clk);
         #1;
         if (wr_strength === 1'b1) begin
            n++;
            if (term_unsettled === 1'b0) dv = dq_term_div;
         end
      end
   endtask
   task automatic test_done();
      if (miscompares == 0 && samples_checked > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   initial begin
      {req_valid, req_chop, req_term, req_read, req_wr_level, req_dll_off, tied_high} = 0;
      {req_cmd, req_wr_term, req_nom_term} = 0;
      req_cwl = 5'h5;
      req_al = 5'h0;
      rst_n = 1'b0;
      repeat (20) @(posedge sys_clk);
      #1 rst_n = 1'b1;
      seed = $urandom(49);
      for (int i = 0; i < 16; i++) begin
         req_cwl = 5'(5 + $urandom % 4);
         req_al = 5'((i == 0) ? 0 : $urandom % 3);
         req_dll_off = (i == 7);
         set_mode(2'(i % 3), 3'(i % 8), 1'b0);
         wr_burst(1'($urandom % 2) | (i == 1));
         chk_cnt(8'(n), (req_wr_term == 2'h0 || req_dll_off) ? 8'h0 : req_chop ? 8'h4 : 8'h6);
         if (n != 0) chk_div(dv, exp_wr(req_wr_term));
         chk_div(dq_term_div, exp_nom(req_nom_term));
         chk_div({3'h0, term_on}, 4'h1);
         req_read = (i % 4 == 0);
         req_term = req_read;
         req(DTC_CMD_NOP);
         repeat (30) @(posedge sys_clk);
         #1;
         chk_div({3'h0, lnk.term_pin}, 4'h0);
         chk_div({3'h0, term_on}, 4'h0);
         chk_div(dq_term_div, DIV_NONE);
         req_read = 1'b0;
      end
      req_dll_off = 1'b0;
      tied_high = 1'b1;
      set_mode(WR_TERM_OFF, NOM_Q4, 1'b1);
      chk_div(dq_term_div, DIV_NONE);
      chk_div(dqs_term_div, DIV_4);
      set_mode(WR_TERM_OFF, NOM_OFF, 1'b0);
      chk_div(dqs_term_div, DIV_NONE);
      set_mode(WR_TERM_Q2, NOM_OFF, 1'b0);
      wr_burst(1'b0);
      chk_cnt(8'(n), 8'h6);
      test_done();
   end
endmodule
